// ==== ring_trip_pkg.sv ====
// Constants, register map and carrier types for the ring trip block.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
`default_nettype none
package ring_trip_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR     = 8'h00;
    localparam logic [7:0] PIN_ADDR      = 8'h04;
    localparam logic [7:0] THR_ADDR      = 8'h08;
    localparam logic [7:0] OFS_ADDR      = 8'h0c;
    localparam logic [7:0] STATUS_ADDR   = 8'h10;
    localparam logic [7:0] METER_LO_ADDR = 8'h14;
    localparam logic [7:0] METER_HI_ADDR = 8'h18;
    localparam int         NCHAN         = 4;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  SRC_RING      = 4'hc;
    localparam logic [2:0]  LS_EXT_RING   = 3'h1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0030;
    // One threshold code is 10 uA
    localparam int          THR_LSB_UA    = 10;
    localparam int          THR_DEF_UA    = 7000;
    localparam int          THR_MAX_UA    = 20000;
    localparam logic [15:0] THR_BUILTIN   = 16'(THR_DEF_UA / THR_LSB_UA);
    localparam logic [15:0] THR_MAX       = 16'(THR_MAX_UA / THR_LSB_UA);
    localparam int          OFS_W         = 14;
    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic [19:0] pad;
        logic        sync_en;
        logic [2:0]  line_state_select;
        logic        ls_update;
        logic        active;
        logic        offset_comp_select;
        logic        thr_builtin;
        logic [3:0]  level_source_select;
    } ctrl_s;
endpackage : ring_trip_pkg
`default_nettype wire

// ==== ring_trip_detect.sv ====
// Ring trip detection for external ringing on four channels, with relay
// pin control and an AXI4-Lite register slave.
// Assumes DC path samples and meter results arrive on aclk; the
// zero-cross and relay pin inputs are asynchronous pins.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`default_nettype none
module ring_trip_detect
    import ring_trip_pkg::*;
(
    // Clock, reset, freeze
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               ce,
    // AXI4-Lite write
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [7:0]         awaddr,
    input  wire logic               wvalid,
    output logic                    wready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    output logic                    bvalid,
    input  wire logic               bready,
    output logic [1:0]              bresp,
    // AXI4-Lite read
    input  wire logic               arvalid,
    output logic                    arready,
    input  wire logic [7:0]         araddr,
    output logic                    rvalid,
    input  wire logic               rready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    // DC path samples
    input  wire logic               smp_valid,
    input  wire logic [1:0]         smp_chan,
    input  wire logic [15:0]        ring_current_input,
    input  wire logic [15:0]        loop_current_input,
    // Level meter result
    input  wire logic               meter_valid,
    input  wire logic [15:0]        meter_result,
    // Zero-cross and relay pins
    input  wire logic               zero_cross_input,
    input  wire logic [NCHAN-1:0]   relay_pin_in,
    output logic [NCHAN-1:0]        relay_pin_out,
    output logic [NCHAN-1:0]        relay_pin_oe,
    // Mode and hook status outputs
    output logic                    codec_active,
    output logic                    line_scan_en,
    output logic [2:0]              line_state,
    output logic [NCHAN-1:0]        hook_status_bits
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return a == CTRL_ADDR || a == PIN_ADDR || a == THR_ADDR ||
               a == OFS_ADDR || a == STATUS_ADDR ||
               a == METER_LO_ADDR || a == METER_HI_ADDR;
    endfunction : mapped

    ctrl_s              ctrl_r;
    logic [31:0]        pin_r;
    logic [15:0]        thr_r;
    logic [OFS_W-1:0]   ofs_r;
    logic [15:0]        meter_r;
    logic               aw_got_r;
    logic               w_got_r;
    logic [7:0]         waddr_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic [2:0]         zc_r;
    logic [NCHAN-1:0]   pin_s1_r;
    logic [NCHAN-1:0]   pin_s2_r;
    logic [NCHAN-1:0]   trip_r;
    logic               do_write;
    logic               zc_edge;
    logic [NCHAN-1:0]   pin_dir;
    logic [NCHAN-1:0]   pin_level;

    assign do_write  = ce && aw_got_r && w_got_r && !bvalid;
    assign pin_dir   = pin_r[NCHAN-1:0];
    assign pin_level = pin_r[2*NCHAN-1:NCHAN];

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b0;
            wready   <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            waddr_r  <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                awready  <= 1'b0;
                aw_got_r <= 1'b1;
                waddr_r  <= awaddr;
            end else if (!aw_got_r && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                w_got_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end else if (!w_got_r && !bvalid) begin
                wready <= 1'b1;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= ctrl_s'(CTRL_RESET);
            pin_r  <= 32'h0000_0000;
            thr_r  <= 16'h0000;
            ofs_r  <= '0;
        end else if (do_write) begin
            unique case (waddr_r)
                CTRL_ADDR: begin
                    // Reserved control bits are dropped so they read 0
                    ctrl_r <= ctrl_s'(merge(32'(ctrl_r), wdata_r, wstrb_r)
                                      & 32'h0000_0fff);
                end
                PIN_ADDR: begin
                    pin_r <= merge(pin_r, wdata_r, wstrb_r) & 32'h0000_00ff;
                end
                THR_ADDR: begin
                    thr_r <= 16'(merge({16'h0000, thr_r}, wdata_r,
                                       wstrb_r));
                end
                OFS_ADDR: begin
                    ofs_r <= OFS_W'(merge({18'h00000, ofs_r}, wdata_r,
                                          wstrb_r));
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
                unique case (araddr)
                    CTRL_ADDR:     rdata <= 32'(ctrl_r);
                    PIN_ADDR:      rdata <= pin_r;
                    THR_ADDR:      rdata <= {16'h0000, thr_r};
                    OFS_ADDR:      rdata <= {18'h00000, ofs_r};
                    STATUS_ADDR:   rdata <= {20'h00000, pin_s2_r,
                                             relay_pin_out,
                                             hook_status_bits};
                    METER_LO_ADDR: rdata <= {24'h000000, meter_r[7:0]};
                    METER_HI_ADDR: rdata <= {24'h000000, meter_r[15:8]};
                    default:       rdata <= 32'h0000_0000;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode outputs and meter capture
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            codec_active <= 1'b0;
            line_scan_en <= 1'b0;
            line_state   <= 3'h0;
        end else if (ce) begin
            codec_active <= ctrl_r.active;
            line_scan_en <= ctrl_r.ls_update;
            if (ctrl_r.ls_update) begin
                line_state <= ctrl_r.line_state_select;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meter_r <= 16'h0000;
        end else if (ce && meter_valid) begin
            meter_r <= meter_result;
        end
    end

    // ------------------------------------------------------------
    // DC path, compensation and threshold compare
    // ------------------------------------------------------------
    logic signed [15:0] path_sample;
    logic signed [16:0] comp;
    logic signed [16:0] sum;
    logic        [15:0] thr_eff;
    logic               over;

    assign path_sample = (ctrl_r.level_source_select == SRC_RING) ?
                         ring_current_input : loop_current_input;
    assign comp = ctrl_r.offset_comp_select ? 17'sh00000 :
                  17'(signed'(ofs_r));
    assign sum  = 17'(path_sample) + comp;
    // threshold source, limited to 20 mA
    assign thr_eff = ctrl_r.thr_builtin ? THR_BUILTIN :
                     (thr_r > THR_MAX) ? THR_MAX : thr_r;
    assign over = sum > signed'({1'b0, thr_eff});

    // Bits only follow samples in active mode, else they read on-hook
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hook_status_bits <= '0;
        end else if (ce) begin
            if (!codec_active) begin
                hook_status_bits <= '0;
            end else if (smp_valid) begin
                hook_status_bits[smp_chan] <= over;
            end
        end
    end

    // ------------------------------------------------------------
    // Zero-cross and relay pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zc_r     <= 3'h0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else if (ce) begin
            zc_r     <= {zc_r[1:0], zero_cross_input};
            pin_s1_r <= relay_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Either polarity counts
    assign zc_edge = zc_r[2] ^ zc_r[1];

    // ------------------------------------------------------------
    // Relay pins
    // ------------------------------------------------------------
    for (genvar i = 0; i < NCHAN; i++) begin : g_relay
        logic sync_mode;
        assign sync_mode = ctrl_r.sync_en && pin_dir[i];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                trip_r[i] <= 1'b0;
            end else if (ce) begin
                if (sync_mode && hook_status_bits[i] && !relay_pin_out[i])
                begin
                    trip_r[i] <= 1'b1;
                end else if (!sync_mode || pin_level[i]) begin
                    trip_r[i] <= 1'b0;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                relay_pin_out[i] <= 1'b0;
                relay_pin_oe[i]  <= 1'b0;
            end else if (ce) begin
                relay_pin_oe[i] <= pin_dir[i];
                if (!pin_dir[i]) begin
                    relay_pin_out[i] <= 1'b0;
                end else if (!ctrl_r.sync_en) begin
                    relay_pin_out[i] <= pin_level[i];
                end else if (trip_r[i]) begin
                    relay_pin_out[i] <= 1'b1;
                end else if (zc_edge) begin
                    relay_pin_out[i] <= pin_level[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    route_ring_a: assert property (
        ctrl_r.level_source_select == SRC_RING |->
        path_sample == ring_current_input)
        else $error("ring current not routed");
    hook_set_a: assert property (
        ce && codec_active && smp_valid && over |=>
        hook_status_bits[$past(smp_chan)])
        else $error("hook bit not set over threshold");
    hook_clr_a: assert property (
        ce && codec_active && smp_valid && !over |=>
        !hook_status_bits[$past(smp_chan)])
        else $error("hook bit set under threshold");
    thr_src_a: assert property (
        ctrl_r.thr_builtin |-> thr_eff == THR_BUILTIN)
        else $error("built-in threshold not used");
    thr_range_a: assert property (
        !ctrl_r.thr_builtin |-> thr_eff <= THR_MAX &&
        (thr_r > THR_MAX || thr_eff == thr_r))
        else $error("threshold word out of range");
    line_mode_a: assert property (
        ce && ctrl_r.ls_update |=>
        line_state == $past(ctrl_r.line_state_select) && line_scan_en)
        else $error("line state not passed on");
    async_pin_a: assert property (
        ce && pin_dir[0] && !ctrl_r.sync_en |=>
        relay_pin_out[0] == $past(pin_level[0]) && relay_pin_oe[0])
        else $error("asynchronous pin wrong");
    sync_hold_a: assert property (
        ce && pin_dir[0] && ctrl_r.sync_en && !zc_edge && !trip_r[0]
        |=> $stable(relay_pin_out[0]))
        else $error("relay switched off zero-cross");
    hw_trip_a: assert property (
        (ce && pin_dir[0] && ctrl_r.sync_en && hook_status_bits[0] &&
         !relay_pin_out[0]) ##1 (ce && pin_dir[0] && ctrl_r.sync_en)
        |=> relay_pin_out[0])
        else $error("hardware trip did not raise pin");
    offset_a: assert property (
        ctrl_r.offset_comp_select |-> sum == 17'(path_sample))
        else $error("compensation applied when disabled");
    meter_cap_a: assert property (
        ce && meter_valid |=> meter_r == $past(meter_result))
        else $error("meter result not captured");

    hook_rise_c: cover property ($rose(hook_status_bits[0]));
    trip_c:      cover property ($rose(trip_r[0]));
    write_c:     cover property (bvalid && bready);
    read_c:      cover property (rvalid && rready);
endmodule : ring_trip_detect
`default_nettype wire

// ==== line_model.sv ====
// Line interface model: DC path samples and ringer zero-cross.
// Assumes the bench calls its tasks from the aclk domain.
`default_nettype none
module line_model (
    // Clock
    input  wire logic   aclk,
    // Samples
    output logic        smp_valid,
    output logic [1:0]  smp_chan,
    output logic [15:0] ring_current_input,
    output logic [15:0] loop_current_input,
    // Ringer sync
    output logic        zero_cross_input
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        smp_valid = 1'b0;
        smp_chan = 2'h0;
        ring_current_input = 16'h0000;
        loop_current_input = 16'h0000;
        zero_cross_input = 1'b0;
    end
    task automatic send(input logic [1:0] c, input logic [15:0] r,
                        input logic [15:0] l);
        @(posedge aclk);
        smp_valid <= 1'b1;
        smp_chan <= c;
        ring_current_input <= r;
        loop_current_input <= l;
        @(posedge aclk);
        smp_valid <= 1'b0;
        // Stale lines show junk so a late capture cannot pass
        ring_current_input <= ~r;
        loop_current_input <= ~l;
    endtask : send
    task automatic zero_cross();
        @(posedge aclk);
        zero_cross_input <= ~zero_cross_input;
    endtask : zero_cross
endmodule : line_model
`default_nettype wire

// ==== ring_trip_detect_bench.sv ====
// Bench for ring_trip_detect: registers, hook compare, relay, meter.
// Assumes line_model supplies samples and zero-cross edges.
`default_nettype none
module ring_trip_detect_bench
    import ring_trip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0;
    logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]       wdata = 32'h0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp, smp_chan;
    logic [31:0]       rdata;
    logic              smp_valid, zero_cross_input, codec_active;
    logic [15:0]       ring_current_input, loop_current_input;
    logic              meter_valid = 1'b0;
    logic [15:0]       meter_result = 16'h0;
    logic [NCHAN-1:0]  relay_pin_out, relay_pin_oe, hook_status_bits;
    logic              line_scan_en;
    logic [2:0]        line_state;
    int                n_errors = 0, comparisons = 0, seed = 44947;
    logic [31:0]       cfg_ctrl [4] = '{32'h7c, 32'h6c, 32'h4c, 32'h70};
    int                cfg_thr_w [4] = '{0, 2500, 300, 700};
    int                cfg_thr [4] = '{700, 2000, 300, 700};
    int                cfg_comp [4] = '{0, 0, 40, 0};

    always #4 aclk = ~aclk;

    ring_trip_detect ring_trip_detect_inst (.aclk, .aresetn, .ce(1'b1),
        .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .smp_valid, .smp_chan,
        .ring_current_input, .loop_current_input, .meter_valid,
        .meter_result, .zero_cross_input, .relay_pin_in(relay_pin_out),
        .relay_pin_out, .relay_pin_oe, .codec_active, .line_scan_en,
        .line_state, .hook_status_bits);
    line_model line_model_inst (.aclk, .smp_valid, .smp_chan,
        .ring_current_input, .loop_current_input, .zero_cross_input);

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
    endtask : wr
    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", 32'(RESP_OKAY), 32'(r));
    endtask : wok
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
    endtask : rd
    // Strict signed compare of offset-corrected sample
    function automatic logic exp_hook(input logic [15:0] s, input int comp,
                                      input int thr);
        return (int'($signed(s)) + comp) > thr;
    endfunction : exp_hook
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Generous bound: whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] s, o, m;
        logic [13:0] ofs;
        logic        ring_src;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL_ADDR, d, r);
        chk("ctrl reset", CTRL_RESET, d);
        rd(8'h1c, d, r);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
        wr(8'h1c, 32'h1, r);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
        $display("register test done");
        // calibrate while the ringer stays idle
        @(posedge aclk);
        meter_valid <= 1'b1;
        meter_result <= 16'hff60;
        @(posedge aclk);
        meter_valid <= 1'b0;
        rd(METER_LO_ADDR, d, r);
        chk("cal lo", 32'h60, d);
        m[7:0] = d[7:0];
        rd(METER_HI_ADDR, d, r);
        chk("cal hi", 32'hff, d);
        m[15:8] = d[7:0];
        ofs = 14'(m >> 2);
        ofs = ~ofs + 14'h1;
        wok(OFS_ADDR, 32'(ofs));
        rd(OFS_ADDR, d, r);
        chk("ofs word", 32'h28, d);
        wok(CTRL_ADDR, CTRL_RESET);
        $display("calibration test done");
        foreach (cfg_ctrl[k]) begin
            wok(THR_ADDR, 32'(cfg_thr_w[k]));
            wok(CTRL_ADDR, cfg_ctrl[k]);
            for (int i = 0; i < 8; i++) begin
                s = (i < 2) ? 16'(cfg_thr[k] - cfg_comp[k] + i)
                            : 16'($random(seed) % 3000);
                o = 16'($random(seed));
                ring_src = cfg_ctrl[k][3:0] == SRC_RING;
                line_model_inst.send(2'(i), ring_src ? s : o,
                                     ring_src ? o : s);
                @(negedge aclk);
                chk("hook", 32'(exp_hook(s, cfg_comp[k], cfg_thr[k])),
                    32'(hook_status_bits[i % 4]));
            end
            $display("threshold test %0d done", k);
        end
        wok(CTRL_ADDR, 32'h1fc);
        repeat (2) @(negedge aclk);
        chk("modes", 32'h1_1_1, 32'({codec_active, 3'h0, line_scan_en,
            1'b0, line_state}));
        wok(CTRL_ADDR, 32'h7c);
        // Channel 0 must read on-hook before the relay runs synchronous
        line_model_inst.send(2'h0, 16'h0000, 16'h0000);
        @(negedge aclk);
        chk("hook idle", 32'h0, 32'(hook_status_bits[0]));
        wok(PIN_ADDR, 32'h11);
        repeat (2) @(negedge aclk);
        chk("relay async", 32'h3,
            32'({relay_pin_oe[0], relay_pin_out[0]}));
        rd(STATUS_ADDR, d, r);
        chk("status pin", 32'h110, d & 32'hff0);
        wok(CTRL_ADDR, 32'h87c);
        wok(PIN_ADDR, 32'h01);
        @(negedge aclk);
        chk("relay held", 32'h1, 32'(relay_pin_out[0]));
        line_model_inst.zero_cross();
        repeat (6) @(negedge aclk);
        chk("relay synced", 32'h0, 32'(relay_pin_out[0]));
        line_model_inst.send(2'h0, 16'd1500, 16'h0);
        repeat (4) @(negedge aclk);
        chk("relay trip", 32'h1, 32'(relay_pin_out[0]));
        $display("relay test done");
        @(posedge aclk);
        meter_valid <= 1'b1;
        meter_result <= 16'habcd;
        @(posedge aclk);
        meter_valid <= 1'b0;
        rd(METER_LO_ADDR, d, r);
        chk("meter lo", 32'hcd, d);
        rd(METER_HI_ADDR, d, r);
        chk("meter hi", 32'hab, d);
        $display("meter test done");
        complete_run();
    end
endmodule : ring_trip_detect_bench
`default_nettype wire
